// ==== rtl/alert_flags_pkg.sv ====
/*
 * shared constants for the uart buffer alert flag bank: register indices,
 * byte addresses, field positions and reset values.
 * assumes a 32-bit apb bus with one aligned word per register index.
 */
package alert_flags_pkg;

    localparam int ADDR_W = 12;

    // register indices; the byte address is four times the index
    localparam logic [7:0] RX_RD_IDX = 8'h11;
    localparam logic [7:0] RX_WR_IDX = 8'h10;
    localparam logic [7:0] TX_RD_IDX = 8'h13;
    localparam logic [7:0] TX_WR_IDX = 8'h12;
    localparam logic [7:0] CFG_IDX = 8'h16;

    localparam logic [ADDR_W-1:0] RX_RD_ADDR = {2'h0, RX_RD_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] RX_WR_ADDR = {2'h0, RX_WR_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] TX_RD_ADDR = {2'h0, TX_RD_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] TX_WR_ADDR = {2'h0, TX_WR_IDX, 2'h0};
    localparam logic [ADDR_W-1:0] CFG_ADDR = {2'h0, CFG_IDX, 2'h0};

    // field positions shared by both alert registers, and the configuration bit
    localparam int BIT_ERR_HELD = 7;
    localparam int BIT_UNUSED = 6;
    localparam int BIT_ACTIVE = 5;
    localparam int BIT_QUIET = 4;
    localparam int BIT_OVERRUN = 3;
    localparam int BIT_NO_SPACE = 2;
    localparam int BIT_STOP_AVAIL = 1;
    localparam int BIT_EMPTY = 0;
    localparam int CFG_BIT_IGNORE = 0;

    // reset values and the read mask
    localparam logic [7:0] ALERT_RESET = 8'h00;
    localparam logic CFG_IGNORE_RESET = 1'b0;
    localparam logic [7:0] FLAG_MASK = 8'hBF;

endpackage

// ==== rtl/apb_decode.sv ====
/*
 * apb address decode for the alert flag bank: write strobes, read selects
 * and the error answer for unmapped or wrong-direction accesses.
 * assumes psel, penable, pwrite and paddr follow apb timing.
 */
`timescale 1ns/1ps
module apb_decode (
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [alert_flags_pkg::ADDR_W-1:0] paddr, // apb byte address
    output logic wr_rx, // write to receive alert register
    output logic wr_tx, // write to transmit alert register
    output logic wr_cfg, // write to configuration register
    output logic rd_rx, // address selects receive alert read
    output logic rd_tx, // address selects transmit alert read
    output logic rd_cfg, // address selects configuration read
    output logic pslverr // error on unmapped access
);
    logic access;
    logic hit;

    // direction-qualified address hits
    assign access = psel & penable;
    assign rd_rx = ~pwrite & (paddr == alert_flags_pkg::RX_RD_ADDR);
    assign rd_tx = ~pwrite & (paddr == alert_flags_pkg::TX_RD_ADDR);
    assign rd_cfg = ~pwrite & (paddr == alert_flags_pkg::CFG_ADDR);
    assign wr_rx = access & pwrite & (paddr == alert_flags_pkg::RX_WR_ADDR);
    assign wr_tx = access & pwrite & (paddr == alert_flags_pkg::TX_WR_ADDR);
    assign wr_cfg = access & pwrite & (paddr == alert_flags_pkg::CFG_ADDR);

    // anything not hit answers with an error and has no effect
    assign hit = rd_rx | rd_tx | rd_cfg | (pwrite & (paddr == alert_flags_pkg::RX_WR_ADDR))
        | (pwrite & (paddr == alert_flags_pkg::TX_WR_ADDR)) | (pwrite & (paddr == alert_flags_pkg::CFG_ADDR));
    assign pslverr = access & ~hit;
endmodule

// ==== rtl/event_flag.sv ====
/*
 * one event-driven alert flag: set on a rising condition or an event pulse,
 * cleared by software write of 0 or by an automatic clear; set wins.
 * assumes all inputs are synchronous to pclk.
 */
`timescale 1ns/1ps
module event_flag (
    input wire logic pclk, // bus clock
    input wire logic presetn, // async reset, active low
    input wire logic cond, // level condition, edge triggers a set
    input wire logic pulse, // event pulse that sets the flag
    input wire logic sw_clr, // software write of 0 to this bit
    input wire logic clr_ok, // software clear permitted now
    input wire logic auto_clr, // hardware clear request
    output logic flag // flag state
);
    logic cond_prev_ff;
    logic flag_ff;
    logic nxt_flag;

    // remember the condition to find its first cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cond_prev_ff <= 1'b0;
        else
            cond_prev_ff <= cond;
    end

    // a new event beats any clear in the same cycle
    assign nxt_flag = (cond & ~cond_prev_ff) | pulse | (flag_ff & ~(sw_clr & clr_ok) & ~auto_clr);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flag_ff <= 1'b0;
        else
            flag_ff <= nxt_flag;
    end

    assign flag = flag_ff;
endmodule

// ==== rtl/uart_buffer_alert_flags.sv ====
/*
 * alert flag bank reporting uart receive buffer and transmit queue state,
 * reached over apb; also gates the load queue when receive space is short.
 * assumes the uart and buffer logic drive the status inputs on pclk.
 */
// The APB register port is this design's own decision.
`timescale 1ns/1ps
// Operation
// [RQ1] receive alerts read 0x11, write 0x10
// [RQ2] bit 7 set on character error
// [RQ3] bit 5 set while receiving
// [RQ4] bit 4 set when not receiving
// [RQ5] bit 3 set when full buffer overwritten
// [RQ6] overrun clears only when buffer not full
// [RQ7] bit 2 set when buffer full
// [RQ8] bit 1 set when framed message ready
// [RQ9] stop flag self-clears on read-out or preamble
// [RQ10] no stop flag on empty buffer
// [RQ11] no stop flag for alert packets
// [RQ12] bit 0 set when nothing unread
// [RQ13] write 0 clears, write 1 keeps
// [RQ14] flags are events, clear despite condition
// [RQ15] transmit alerts read 0x13, write 0x12
// [RQ16] hold load queue when receive space short
// [RQ17] transmit overrun when queue cannot advance
// [RQ18] transmit full when load one behind
// [RQ19] transmit empty when load equals transmit
// [RQ20] bit 6 reads zero, writes ignored
// [RQ21] flags zero at reset, set at onset
module uart_buffer_alert_flags #(
    parameter int PTR_W = 8, // receive buffer pointer width
    parameter int Q_W = 2, // transmit queue index width
    parameter int LEN_W = 8 // message length width
) (
    input wire logic pclk, // bus clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [alert_flags_pkg::ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic rx_char_error, // byte at read pointer had a bad char
    input wire logic rx_busy, // uart is receiving
    input wire logic rx_overwrite, // pulse: full buffer byte overwritten
    input wire logic rx_stop_char, // pulse: framed stop character seen
    input wire logic automated_alert_packet, // current message is an alert packet
    input wire logic rx_preamble, // pulse: new preamble detected
    input wire logic rx_messages_waiting, // unread messages remain
    input wire logic [PTR_W-1:0] rx_read_pointer, // receive read pointer
    input wire logic [PTR_W-1:0] rx_write_pointer, // receive write pointer
    input wire logic tx_busy, // uart is transmitting
    input wire logic tx_advance_blocked, // pulse: load queue could not advance
    input wire logic [Q_W-1:0] load_queue_index, // queue being loaded
    input wire logic [Q_W-1:0] tx_queue_index, // queue being transmitted
    input wire logic [LEN_W-1:0] tx_message_length, // bytes in load queue message
    output logic tx_hold_load // withhold the load queue
);
    logic [7:0] rx_cond;
    logic [7:0] rx_pulse;
    logic [7:0] rx_clr_ok;
    logic [7:0] rx_auto;
    logic [7:0] rx_flags;
    logic [7:0] tx_cond;
    logic [7:0] tx_pulse;
    logic [7:0] tx_flags;
    logic wr_rx;
    logic wr_tx;
    logic wr_cfg;
    logic rd_rx;
    logic rd_tx;
    logic rd_cfg;
    logic ignore_rx_space_check_ff;
    logic tx_hold_load_ff;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic rx_empty;
    logic rx_full;
    logic rx_space_short;
    logic tx_full;
    logic tx_empty;
    logic stop_set;
    logic held_cond;

    // distance from b forward to a around a pointer ring
    function automatic logic [PTR_W-1:0] ring_gap(input logic [PTR_W-1:0] a, input logic [PTR_W-1:0] b);
        return a - b;
    endfunction

    // apb address decode and error answer
    apb_decode u_decode (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .wr_rx(wr_rx),
        .wr_tx(wr_tx),
        .wr_cfg(wr_cfg),
        .rd_rx(rd_rx),
        .rd_tx(rd_tx),
        .rd_cfg(rd_cfg),
        .pslverr(pslverr)
    );

    // every access completes in its first access cycle
    assign pready = 1'b1;

    // receive buffer occupancy from the pointers
    assign rx_empty = ring_gap(rx_write_pointer, rx_read_pointer) == PTR_W'(1); // RQ12
    assign rx_full = ring_gap(rx_write_pointer, rx_read_pointer) == PTR_W'(0); // RQ7
    assign rx_space_short = {{LEN_W{1'b0}}, ring_gap(rx_read_pointer, rx_write_pointer)}
        < {{PTR_W{1'b0}}, tx_message_length};

    // transmit queue occupancy from the queue indices
    assign tx_full = load_queue_index == Q_W'(tx_queue_index - 1'b1); // RQ18
    assign tx_empty = load_queue_index == tx_queue_index; // RQ19

    // stop flag only for real messages landing in a non-empty buffer
    assign stop_set = rx_stop_char & ~automated_alert_packet & ~rx_empty; // RQ8 RQ10 RQ11

    // receive set conditions per bit
    always_comb
    begin
        rx_cond = 8'h00;
        rx_pulse = 8'h00;
        rx_cond[alert_flags_pkg::BIT_ERR_HELD] = rx_char_error; // RQ2
        rx_cond[alert_flags_pkg::BIT_ACTIVE] = rx_busy; // RQ3
        rx_cond[alert_flags_pkg::BIT_QUIET] = ~rx_busy; // RQ4
        rx_pulse[alert_flags_pkg::BIT_OVERRUN] = rx_overwrite; // RQ5
        rx_cond[alert_flags_pkg::BIT_NO_SPACE] = rx_full; // RQ7
        rx_pulse[alert_flags_pkg::BIT_STOP_AVAIL] = stop_set; // RQ8
        rx_cond[alert_flags_pkg::BIT_EMPTY] = rx_empty; // RQ12
    end

    // receive clear qualifiers and automatic clears
    always_comb
    begin
        rx_clr_ok = 8'hFF;
        rx_auto = 8'h00;
        rx_clr_ok[alert_flags_pkg::BIT_OVERRUN] = ~rx_full; // RQ6
        rx_auto[alert_flags_pkg::BIT_STOP_AVAIL] = rx_preamble | ~rx_messages_waiting; // RQ9
    end

    // withholding applies only with space checking on and a message loaded
    assign held_cond = rx_space_short & ~ignore_rx_space_check_ff & ~tx_empty; // RQ16

    // transmit set conditions per bit
    always_comb
    begin
        tx_cond = 8'h00;
        tx_pulse = 8'h00;
        tx_cond[alert_flags_pkg::BIT_ERR_HELD] = held_cond; // RQ16
        tx_cond[alert_flags_pkg::BIT_ACTIVE] = tx_busy;
        tx_cond[alert_flags_pkg::BIT_QUIET] = ~tx_busy;
        tx_pulse[alert_flags_pkg::BIT_OVERRUN] = tx_advance_blocked; // RQ17
        tx_cond[alert_flags_pkg::BIT_NO_SPACE] = tx_full; // RQ18
        tx_cond[alert_flags_pkg::BIT_STOP_AVAIL] = ~tx_full;
        tx_cond[alert_flags_pkg::BIT_EMPTY] = tx_empty; // RQ19
    end

    // one event flag per used bit; bit 6 has none
    for (genvar i = 0; i < 8; i++)
    begin : g_flags
        if (i == alert_flags_pkg::BIT_UNUSED)
        begin : g_unused
            assign rx_flags[i] = 1'b0; // RQ20
            assign tx_flags[i] = 1'b0; // RQ20
        end
        else
        begin : g_used
            event_flag u_rx (
                .pclk(pclk),
                .presetn(presetn),
                .cond(rx_cond[i]),
                .pulse(rx_pulse[i]),
                .sw_clr(wr_rx & ~pwdata[i]), // RQ1 RQ13 RQ14
                .clr_ok(rx_clr_ok[i]),
                .auto_clr(rx_auto[i]),
                .flag(rx_flags[i]) // RQ21
            );
            event_flag u_tx (
                .pclk(pclk),
                .presetn(presetn),
                .cond(tx_cond[i]),
                .pulse(tx_pulse[i]),
                .sw_clr(wr_tx & ~pwdata[i]), // RQ15 RQ13 RQ14
                .clr_ok(1'b1),
                .auto_clr(1'b0),
                .flag(tx_flags[i]) // RQ21
            );
        end
    end

    // configuration: space check override
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ignore_rx_space_check_ff <= alert_flags_pkg::CFG_IGNORE_RESET;
        else if (wr_cfg)
            ignore_rx_space_check_ff <= pwdata[alert_flags_pkg::CFG_BIT_IGNORE];
    end

    // load queue hold toward the transmit buffer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_hold_load_ff <= 1'b0;
        else
            tx_hold_load_ff <= held_cond; // RQ16
    end

    assign tx_hold_load = tx_hold_load_ff;

    // read data captured in the setup cycle
    always_comb
    begin
        nxt_prdata = prdata_ff;
        if (psel && !penable)
        begin
            nxt_prdata = 32'h0000_0000;
            if (rd_rx)
                nxt_prdata[7:0] = rx_flags & alert_flags_pkg::FLAG_MASK; // RQ1 RQ20
            else if (rd_tx)
                nxt_prdata[7:0] = tx_flags & alert_flags_pkg::FLAG_MASK; // RQ15 RQ20
            else if (rd_cfg)
                nxt_prdata[alert_flags_pkg::CFG_BIT_IGNORE] = ignore_rx_space_check_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_ff <= 32'h0000_0000;
        else
            prdata_ff <= nxt_prdata;
    end

    assign prdata = prdata_ff;

    // receive read returns the flags seen at the setup edge
    a_rx_read_data: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
        psel && penable && !pwrite && paddr == alert_flags_pkg::RX_RD_ADDR
        |-> prdata[7:0] == ($past(rx_flags) & alert_flags_pkg::FLAG_MASK))
        else $error("receive alert read data wrong");

    // transmit read returns the flags seen at the setup edge
    a_tx_read_data: assert property (@(posedge pclk) disable iff (!presetn) // RQ15
        psel && penable && !pwrite && paddr == alert_flags_pkg::TX_RD_ADDR
        |-> prdata[7:0] == $past(tx_flags) && prdata[31:8] == 24'h000000)
        else $error("transmit alert read data wrong");

    // unused bit never reads as one
    a_unused_bit_zero: assert property (@(posedge pclk) disable iff (!presetn) // RQ20
        psel && penable && !pwrite && (paddr == alert_flags_pkg::RX_RD_ADDR || paddr == alert_flags_pkg::TX_RD_ADDR)
        |-> !prdata[6])
        else $error("unused bit read as one");

    // receive activity onset raises the busy flag next cycle
    a_rx_busy_onset: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
        $rose(rx_busy) |=> rx_flags[alert_flags_pkg::BIT_ACTIVE])
        else $error("receive busy flag not set");

    // end of reception raises the idle flag next cycle
    a_rx_idle_onset: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
        $fell(rx_busy) |=> rx_flags[alert_flags_pkg::BIT_QUIET])
        else $error("receive idle flag not set");

    // an overwrite event raises the overrun flag
    a_rx_overrun_set: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
        rx_overwrite |=> rx_flags[alert_flags_pkg::BIT_OVERRUN])
        else $error("receive overrun flag not set");

    // writing 0 clears busy even while receiving continues
    a_wr_zero_clears: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
        wr_rx && !pwdata[alert_flags_pkg::BIT_ACTIVE] && !$rose(rx_busy)
        |=> !rx_flags[alert_flags_pkg::BIT_ACTIVE]
        ##1 (!rx_flags[alert_flags_pkg::BIT_ACTIVE] || ($past(rx_busy) && !$past(rx_busy, 2))))
        else $error("write of zero did not clear busy");

    // writing 1 leaves a set flag alone
    a_wr_one_keeps: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
        wr_rx && pwdata[alert_flags_pkg::BIT_ERR_HELD] && rx_flags[alert_flags_pkg::BIT_ERR_HELD]
        |=> rx_flags[alert_flags_pkg::BIT_ERR_HELD])
        else $error("write of one changed a flag");

    // overrun survives a clear while the buffer is full
    a_ovr_clear_block: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
        wr_rx && !pwdata[alert_flags_pkg::BIT_OVERRUN] && rx_full && rx_flags[alert_flags_pkg::BIT_OVERRUN]
        |=> rx_flags[alert_flags_pkg::BIT_OVERRUN])
        else $error("overrun cleared while full");

    // stop on an empty buffer or from an alert packet sets nothing
    a_stop_no_set: assert property (@(posedge pclk) disable iff (!presetn) // RQ10 RQ11
        rx_stop_char && (rx_empty || automated_alert_packet) && !rx_flags[alert_flags_pkg::BIT_STOP_AVAIL]
        |=> !rx_flags[alert_flags_pkg::BIT_STOP_AVAIL])
        else $error("stop flag set wrongly");

    // preamble without a new stop clears the stop flag
    a_stop_auto_clr: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
        rx_preamble && !stop_set |=> !rx_flags[alert_flags_pkg::BIT_STOP_AVAIL])
        else $error("stop flag not cleared by preamble");

    // override keeps the load queue flowing and held flag quiet
    a_hold_override: assert property (@(posedge pclk) disable iff (!presetn) // RQ16
        ignore_rx_space_check_ff && !tx_flags[alert_flags_pkg::BIT_ERR_HELD]
        |=> !tx_flags[alert_flags_pkg::BIT_ERR_HELD] ##0 (!tx_hold_load || !$past(ignore_rx_space_check_ff)))
        else $error("load queue held despite override");

    // transmit full and empty flags follow queue index onset
    a_tx_full_onset: assert property (@(posedge pclk) disable iff (!presetn) // RQ18
        $rose(tx_full) |=> tx_flags[alert_flags_pkg::BIT_NO_SPACE])
        else $error("transmit full flag not set");

    a_tx_empty_onset: assert property (@(posedge pclk) disable iff (!presetn) // RQ19
        $rose(tx_empty) |=> tx_flags[alert_flags_pkg::BIT_EMPTY])
        else $error("transmit empty flag not set");
endmodule

// ==== bench/rx_buffer_model.sv ====
/*
 * receive buffer model for the alert flag bench: read and write pointers
 * and an overwrite pulse when a byte arrives at a full buffer.
 * assumes push and pop are driven just after pclk rising edges.
 */
`timescale 1ns/1ps
module rx_buffer_model #(
    parameter int PTR_W = 4 // pointer width
) (
    input wire logic pclk, // bus clock
    input wire logic presetn, // async reset, active low
    input wire logic push, // a byte arrives this cycle
    input wire logic pop, // host reads a byte this cycle
    output logic [PTR_W-1:0] rd_ptr, // read pointer
    output logic [PTR_W-1:0] wr_ptr, // write pointer
    output logic overwrite // pulse: full buffer byte overwritten
);
    logic [PTR_W-1:0] rd_ptr_ff;
    logic [PTR_W-1:0] wr_ptr_ff;
    logic overwrite_ff;
    logic full;
    logic empty;

    // empty keeps write one ahead of read, full when the two meet
    assign full = (wr_ptr_ff == rd_ptr_ff);
    assign empty = ((wr_ptr_ff - rd_ptr_ff) == PTR_W'(1));
    assign rd_ptr = rd_ptr_ff;
    assign wr_ptr = wr_ptr_ff;
    assign overwrite = overwrite_ff;

    // write side: a byte into a full buffer overwrites and does not advance
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr_ff <= PTR_W'(1);
            overwrite_ff <= 1'b0;
        end
        else
        begin
            overwrite_ff <= push && full;
            if (push && !full)
                wr_ptr_ff <= wr_ptr_ff + PTR_W'(1);
        end
    end

    // read side: a read of an empty buffer is dropped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rd_ptr_ff <= '0;
        else if (pop && !empty)
            rd_ptr_ff <= rd_ptr_ff + PTR_W'(1);
    end
endmodule

// ==== bench/uart_buffer_alert_flags_tb.sv ====
/*
 * self-checking bench for the alert flag bank: apb master tasks, one task
 * per scenario, and a receive buffer model driving the pointer inputs.
 * assumes zero-wait apb answers and flags visible one cycle after onset.
 */
`timescale 1ns/1ps
module uart_buffer_alert_flags_tb;
    localparam int PTR_W = 4;
    localparam int Q_W = 2;
    localparam int LEN_W = 8;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [alert_flags_pkg::ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic rx_char_error, rx_busy, rx_overwrite, rx_stop_char, alert_pkt, rx_preamble, rx_waiting;
    logic push, pop, tx_busy, tx_blocked, tx_hold_load;
    logic [PTR_W-1:0] rd_ptr, wr_ptr;
    logic [Q_W-1:0] load_idx, xmit_idx;
    logic [LEN_W-1:0] msg_len;
    int failures = 0;
    int total_checks = 0;

    uart_buffer_alert_flags #(.PTR_W(PTR_W), .Q_W(Q_W), .LEN_W(LEN_W)) i_uart_buffer_alert_flags (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_char_error(rx_char_error), .rx_busy(rx_busy), .rx_overwrite(rx_overwrite),
        .rx_stop_char(rx_stop_char), .automated_alert_packet(alert_pkt), .rx_preamble(rx_preamble),
        .rx_messages_waiting(rx_waiting), .rx_read_pointer(rd_ptr), .rx_write_pointer(wr_ptr),
        .tx_busy(tx_busy), .tx_advance_blocked(tx_blocked), .load_queue_index(load_idx),
        .tx_queue_index(xmit_idx), .tx_message_length(msg_len), .tx_hold_load(tx_hold_load));

    rx_buffer_model #(.PTR_W(PTR_W)) i_rx_buffer_model (
        .pclk(pclk), .presetn(presetn), .push(push), .pop(pop),
        .rd_ptr(rd_ptr), .wr_ptr(wr_ptr), .overwrite(rx_overwrite));

    // free-running bus clock, 40 ns period
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic finish_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_flag(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask

    // one apb transfer; two spare edges first let any earlier release land
    task automatic apb(input logic [alert_flags_pkg::ADDR_W-1:0] a, input logic w, input logic [31:0] d);
        repeat (2) @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_exp(input string name, input logic [alert_flags_pkg::ADDR_W-1:0] a, input logic [7:0] exp);
        apb(a, 1'b0, 32'h0);
        check_val(name, {24'h000000, exp}, rdata);
        check_flag("pslverr on read", 1'b0, err);
        check_flag("pready on read", 1'b1, pready);
    endtask

    // raise one event input for n cycles: 0 stop, 1 preamble, 2 push, 3 pop, 4 blocked
    task automatic pulse(input int sel, input int n);
        @(posedge pclk);
        case (sel)
            0: rx_stop_char <= 1'b1;
            1: rx_preamble <= 1'b1;
            2: push <= 1'b1;
            3: pop <= 1'b1;
            default: tx_blocked <= 1'b1;
        endcase
        repeat (n) @(posedge pclk);
        {rx_stop_char, rx_preamble, push, pop, tx_blocked} <= 5'h00;
    endtask

    task automatic t_reset_and_clear();
        rd_exp("rx after reset", alert_flags_pkg::RX_RD_ADDR, 8'h11);
        rd_exp("tx after reset", alert_flags_pkg::TX_RD_ADDR, 8'h13);
        apb(alert_flags_pkg::RX_WR_ADDR, 1'b1, 32'h000000EF);
        rd_exp("rx write one keeps", alert_flags_pkg::RX_RD_ADDR, 8'h01);
        apb(alert_flags_pkg::RX_WR_ADDR, 1'b1, 32'h00000000);
        rd_exp("rx write zero clears", alert_flags_pkg::RX_RD_ADDR, 8'h00);
        apb(alert_flags_pkg::TX_WR_ADDR, 1'b1, 32'h00000000);
        rd_exp("tx write zero clears", alert_flags_pkg::TX_RD_ADDR, 8'h00);
    endtask

    task automatic t_refused();
        apb(12'h07C, 1'b0, 32'h0);
        check_flag("unmapped pslverr", 1'b1, err);
        check_val("unmapped prdata", 32'h00000000, rdata);
        apb(alert_flags_pkg::RX_WR_ADDR, 1'b0, 32'h0);
        check_flag("read of write address", 1'b1, err);
        apb(alert_flags_pkg::TX_RD_ADDR, 1'b1, 32'h0);
        check_flag("write to read address", 1'b1, err);
    endtask

    task automatic t_tx_queue();
        @(posedge pclk);
        load_idx <= 2'h3;
        msg_len <= 8'h10;
        pulse(4, 1);
        repeat (2) @(posedge pclk);
        check_flag("tx_hold_load short space", 1'b1, tx_hold_load);
        rd_exp("tx held full overrun", alert_flags_pkg::TX_RD_ADDR, 8'h8C);
        apb(alert_flags_pkg::CFG_ADDR, 1'b1, 32'h00000001);
        repeat (3) @(posedge pclk);
        check_flag("tx_hold_load ignored", 1'b0, tx_hold_load);
        apb(alert_flags_pkg::TX_WR_ADDR, 1'b1, 32'h00000000);
        @(posedge pclk);
        load_idx <= 2'h0;
        tx_busy <= 1'b1;
        rd_exp("tx empty avail busy", alert_flags_pkg::TX_RD_ADDR, 8'h23);
    endtask

    task automatic t_rx_status();
        @(posedge pclk);
        rx_busy <= 1'b1;
        @(posedge pclk);
        rx_busy <= 1'b0;
        rx_char_error <= 1'b1;
        rd_exp("rx error busy idle", alert_flags_pkg::RX_RD_ADDR, 8'hB0);
        apb(alert_flags_pkg::RX_WR_ADDR, 1'b1, 32'h000000FF);
        rd_exp("rx write ones keep", alert_flags_pkg::RX_RD_ADDR, 8'hB0);
        apb(alert_flags_pkg::RX_WR_ADDR, 1'b1, 32'h00000000);
        rd_exp("rx clear with error held", alert_flags_pkg::RX_RD_ADDR, 8'h00);
        rx_char_error <= 1'b0;
    endtask

    task automatic t_stop();
        rx_waiting <= 1'b1;
        pulse(0, 1);
        rd_exp("stop on empty buffer", alert_flags_pkg::RX_RD_ADDR, 8'h00);
        pulse(2, 1);
        alert_pkt <= 1'b1;
        pulse(0, 1);
        rd_exp("stop of alert packet", alert_flags_pkg::RX_RD_ADDR, 8'h00);
        alert_pkt <= 1'b0;
        pulse(0, 1);
        rd_exp("stop received", alert_flags_pkg::RX_RD_ADDR, 8'h02);
        pulse(1, 1);
        rd_exp("stop after preamble", alert_flags_pkg::RX_RD_ADDR, 8'h00);
        pulse(0, 1);
        rx_waiting <= 1'b0;
        rd_exp("stop after read out", alert_flags_pkg::RX_RD_ADDR, 8'h00);
        pulse(3, 1);
        apb(alert_flags_pkg::RX_WR_ADDR, 1'b1, 32'h00000000);
    endtask

    task automatic t_fill();
        pulse(2, 16);
        rd_exp("rx full and overrun", alert_flags_pkg::RX_RD_ADDR, 8'h0C);
        apb(alert_flags_pkg::RX_WR_ADDR, 1'b1, 32'h00000000);
        rd_exp("overrun kept while full", alert_flags_pkg::RX_RD_ADDR, 8'h08);
        pulse(3, 1);
        apb(alert_flags_pkg::RX_WR_ADDR, 1'b1, 32'h00000000);
        rd_exp("overrun cleared", alert_flags_pkg::RX_RD_ADDR, 8'h00);
        pulse(3, 14);
        rd_exp("rx drained empty", alert_flags_pkg::RX_RD_ADDR, 8'h01);
    endtask

    // watchdog: far beyond the few hundred cycles the scenarios need
    initial
    begin
        repeat (5000) @(posedge pclk);
        failures++;
        finish_test();
    end

    // reset for 20 cycles, then the scenarios in order
    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {rx_char_error, rx_busy, rx_stop_char, alert_pkt, rx_preamble, rx_waiting} = '0;
        {push, pop, tx_busy, tx_blocked, load_idx, xmit_idx, msg_len} = '0;
        repeat (20) @(posedge pclk);
        check_val("prdata in reset", 32'h00000000, prdata);
        check_flag("tx_hold_load in reset", 1'b0, tx_hold_load);
        presetn <= 1'b1;
        t_reset_and_clear();
        t_refused();
        t_tx_queue();
        t_rx_status();
        t_stop();
        t_fill();
        finish_test();
    end
endmodule
